// ===== core/ats_seq.sv
// autotune sequencer for one control loop per run
// assumes the modelling engine and heater loop sit outside as ports
//
// Contract
// - entering tuning sets state idle and blanks all three gains
// - start refused unless the loop is in closed-loop control
// - start refused when the input reports sensor units
// - loop select picks one loop per run
// - heater power steps limited to plus or minus the step setting, as a percent of current power; a setting of 100 or more allows full-scale steps
// - mode chooses P only, PI, or PID gain generation
// - modelling fails when not converged within the timeout seconds
// - start enters stabilise only after initialisation succeeds
// - status is one of idle, stabilise, running, complete, failed, aborted
// - stabilise time is not counted against the timeout
// - stabilise holds until power and temperature settle, or abort
// - success reports complete and loads the generated gains
// - gains stay blank until a run completes successfully
// - commit copies gains to the loop, resumes control, exits
// - escape after completion discards gains and exits unchanged
// - escape aborts the run from stabilise or running
// - failed on non-convergence or no valid gains derivable
// - aborted when a user stop or escape ends the run
// - over-temperature disconnects heater and aborts the run
`timescale 1ns/1ns
`include "ats_defs.svh"
module ats_seq #(
    parameter int TICK_CYC = `ATS_TICK_CYC,
    parameter int LOOPS = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enter_key,
    input wire logic go_key,
    input wire logic escape_key,
    input wire logic stop_key,
    input wire logic commit_key,
    input wire logic [$clog2(LOOPS)-1:0] loop_sel,
    input wire logic [6:0] max_power_step_pct,
    input wire ats_pkg::ats_mode_e prop_integral_code,
    input wire logic [15:0] timeout_s,
    input wire logic loop_closed,
    input wire logic units_raw,
    input wire logic init_ok,
    input wire logic power_stable,
    input wire logic temp_stable,
    input wire logic over_temp,
    input wire logic [9:0] cur_power,
    input wire logic [9:0] req_power,
    input wire logic model_done,
    input wire logic model_ok,
    input wire logic [31:0] gen_p,
    input wire logic [31:0] gen_i,
    input wire logic [31:0] gen_d,
    output ats_pkg::ats_state_e status,
    output ats_pkg::ats_gains_s gains,
    output logic model_run,
    output logic [9:0] heater_power,
    output logic heater_off,
    output logic in_tune,
    output logic [$clog2(LOOPS)-1:0] tune_loop,
    output logic apply_gains,
    output logic [$clog2(LOOPS)-1:0] apply_loop,
    output logic resume_ctrl
);
    localparam int LW = $clog2(LOOPS);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_r;
    logic rst_n;

    // clocked release, so all state leaves reset on one edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic ats_pkg::ats_gains_s blank_gains();
        ats_pkg::ats_gains_s g;
        g = '0;
        return g;
    endfunction : blank_gains

    function automatic ats_pkg::ats_gains_s mask_gains(
        input ats_pkg::ats_mode_e m,
        input logic [31:0] p,
        input logic [31:0] i,
        input logic [31:0] d
    );
        ats_pkg::ats_gains_s g;
        g = '0;
        g.p_valid = 1'b1;
        g.p = p;
        g.i_valid = (m != ats_pkg::MODE_P);
        g.i = g.i_valid ? i : 32'h0;
        g.d_valid = (m == ats_pkg::MODE_PID);
        g.d = g.d_valid ? d : 32'h0;
        return g;
    endfunction : mask_gains

    // ----------------------------------------
    // tick and step limiter
    // ----------------------------------------
    logic tick;
    logic tick_restart;
    logic [9:0] lim_power;

    ats_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .restart(tick_restart),
        .tick(tick)
    );

    ats_step u_step (
        .cur_power(cur_power),
        .req_power(req_power),
        .step_pct(max_power_step_pct),
        .lim_power(lim_power)
    );

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    ats_pkg::ats_state_e st_r;
    ats_pkg::ats_state_e st_nxt;
    ats_pkg::ats_gains_s gains_r;
    ats_pkg::ats_gains_s gains_nxt;
    ats_pkg::ats_mode_e mode_r;
    ats_pkg::ats_mode_e mode_nxt;
    logic in_tune_r;
    logic in_tune_nxt;
    logic [LW-1:0] loop_r;
    logic [LW-1:0] loop_nxt;
    logic [15:0] secs_r;
    logic [15:0] secs_nxt;
    logic [15:0] limit_r;
    logic [15:0] limit_nxt;
    logic [9:0] pow_r;
    logic [9:0] pow_nxt;
    logic apply_r;
    logic apply_nxt;
    logic resume_r;
    logic resume_nxt;
    logic start_ok;
    logic abort_req;

    // ----------------------------------------
    // start and abort gates
    // ----------------------------------------
    // start gate: closed loop, temperature units, init done
    assign start_ok = loop_closed && !units_raw && init_ok;
    assign abort_req = escape_key || stop_key || over_temp;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        gains_nxt = gains_r;
        mode_nxt = mode_r;
        in_tune_nxt = in_tune_r;
        loop_nxt = loop_r;
        secs_nxt = secs_r;
        limit_nxt = limit_r;
        pow_nxt = pow_r;
        apply_nxt = 1'b0;
        resume_nxt = 1'b0;
        tick_restart = 1'b0;
        if (!in_tune_r) begin
            if (enter_key) begin
                in_tune_nxt = 1'b1;
                st_nxt = ats_pkg::ST_IDLE;
                gains_nxt = blank_gains();
            end
        end else begin
            case (st_r)
            ats_pkg::ST_IDLE: begin
                if (escape_key) begin
                    in_tune_nxt = 1'b0;
                end else if (go_key && start_ok) begin
                    st_nxt = ats_pkg::ST_STAB;
                    loop_nxt = loop_sel;
                    mode_nxt = prop_integral_code;
                    limit_nxt = timeout_s;
                end
            end
            ats_pkg::ST_STAB: begin
                // no timeout here; waits indefinitely
                if (abort_req) begin
                    st_nxt = ats_pkg::ST_ABORT;
                end else if (power_stable && temp_stable) begin
                    st_nxt = ats_pkg::ST_RUN;
                    secs_nxt = 16'h0;
                    tick_restart = 1'b1;
                    // first step is taken from the power held now
                    pow_nxt = cur_power;
                end
            end
            ats_pkg::ST_RUN: begin
                pow_nxt = lim_power;
                if (tick) begin
                    secs_nxt = secs_r + 16'h1;
                end
                // abort beats a result, a result beats the timeout
                if (abort_req) begin
                    st_nxt = ats_pkg::ST_ABORT;
                end else if (model_done && model_ok) begin
                    st_nxt = ats_pkg::ST_DONE;
                    gains_nxt = mask_gains(mode_r, gen_p, gen_i, gen_d);
                end else if (model_done) begin
                    st_nxt = ats_pkg::ST_FAIL;
                end else if (secs_r >= limit_r) begin
                    st_nxt = ats_pkg::ST_FAIL;
                end
            end
            ats_pkg::ST_DONE: begin
                // commit wins when both keys land together
                if (commit_key) begin
                    apply_nxt = 1'b1;
                    resume_nxt = 1'b1;
                    in_tune_nxt = 1'b0;
                    st_nxt = ats_pkg::ST_IDLE;
                end else if (escape_key) begin
                    gains_nxt = blank_gains();
                    in_tune_nxt = 1'b0;
                    st_nxt = ats_pkg::ST_IDLE;
                end
            end
            ats_pkg::ST_FAIL, ats_pkg::ST_ABORT: begin
                // commit ignored; escape leaves with gains kept blank
                if (escape_key) begin
                    in_tune_nxt = 1'b0;
                    st_nxt = ats_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = ats_pkg::ST_IDLE;
            end
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ats_pkg::ST_IDLE;
            gains_r <= '0;
            mode_r <= ats_pkg::MODE_PI;
            in_tune_r <= 1'b0;
            loop_r <= '0;
            secs_r <= 16'h0;
            limit_r <= `ATS_TIMEOUT_RST;
            pow_r <= 10'h0;
            apply_r <= 1'b0;
            resume_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            gains_r <= gains_nxt;
            mode_r <= mode_nxt;
            in_tune_r <= in_tune_nxt;
            loop_r <= loop_nxt;
            secs_r <= secs_nxt;
            limit_r <= limit_nxt;
            pow_r <= pow_nxt;
            apply_r <= apply_nxt;
            resume_r <= resume_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign status = st_r;
    assign gains = gains_r;
    // from registers only, so keys cannot glitch the engine
    assign model_run = in_tune_r && st_r == ats_pkg::ST_RUN;
    assign heater_power = pow_r;
    // disconnect holds only while the fault stands
    assign heater_off = over_temp;
    assign in_tune = in_tune_r;
    assign tune_loop = loop_r;
    assign apply_gains = apply_r;
    assign apply_loop = loop_r;
    assign resume_ctrl = resume_r;
endmodule : ats_seq

// ===== core/ats_defs.svh
// constants for the autotune sequencer: timing counts and setting defaults
// assumes inclusion by bare name from the design files
`ifndef ATS_DEFS_SVH
`define ATS_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define ATS_CLK_MHZ 100
`define ATS_TICK_NS 1000000000
`define ATS_TICK_CYC (`ATS_TICK_NS / 1000 * `ATS_CLK_MHZ)

// ----------------------------------------
// settings
// ----------------------------------------
`define ATS_PCT_FULL 7'd100
`define ATS_TIMEOUT_RST 16'h00B4
`define ATS_STEP_RST 7'h14

`endif

// ===== core/ats_pkg.sv
// types shared by the autotune sequencer files
// assumes the defs header sits beside it
package ats_pkg;

    // ----------------------------------------
    // status codes, one-hot
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_STAB = 6'h02,
        ST_RUN = 6'h04,
        ST_DONE = 6'h08,
        ST_FAIL = 6'h10,
        ST_ABORT = 6'h20
    } ats_state_e;

    typedef enum logic [1:0] {
        MODE_P = 2'h0,
        MODE_PI = 2'h1,
        MODE_PID = 2'h2
    } ats_mode_e;

    // ----------------------------------------
    // gain triple with validity
    // ----------------------------------------
    typedef struct packed {
        logic p_valid;
        logic i_valid;
        logic d_valid;
        logic [31:0] p;
        logic [31:0] i;
        logic [31:0] d;
    } ats_gains_s;

endpackage : ats_pkg

// ===== core/ats_tick.sv
// one-second tick generator, restarted on demand
// assumes a 100 MHz clock and a synchronised active-low reset
`timescale 1ns/1ns
`include "ats_defs.svh"
module ats_tick #(
    parameter int TICK_CYC = `ATS_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    output logic tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r + 32'h1;
        if (restart || cnt_r == 32'(TICK_CYC - 1)) begin
            cnt_nxt = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tick = !restart && cnt_r == 32'(TICK_CYC - 1);
endmodule : ats_tick

// ===== core/ats_step.sv
// clamps a requested heater power change to the allowed step
// assumes power in percent with one decimal, 0..1000
`timescale 1ns/1ns
`include "ats_defs.svh"
module ats_step (
    input wire logic [9:0] cur_power,
    input wire logic [9:0] req_power,
    input wire logic [6:0] step_pct,
    output logic [9:0] lim_power
);
    logic [16:0] prod;
    logic [9:0] span;
    logic [10:0] hi;

    always_comb begin
        prod = 17'(cur_power) * 17'(step_pct);
        span = 10'(prod / 17'h00064);
        // full-scale steps allowed at one hundred percent
        if (step_pct >= `ATS_PCT_FULL) begin
            span = 10'h3E8;
        end
        hi = 11'(cur_power) + 11'(span);
        // clamp at full scale so a high output cannot wrap
        if (hi > 11'h3E8) begin
            hi = 11'h3E8;
        end
        lim_power = req_power;
        if (11'(req_power) > hi) begin
            lim_power = hi[9:0];
        end else if (cur_power > span && req_power < cur_power - span) begin
            lim_power = cur_power - span;
        end else if (cur_power <= span) begin
            lim_power = req_power;
        end
    end
endmodule : ats_step

// ===== sim/ats_properties.sv
// checker for the autotune sequencer, bound to its top module
// assumes keys are one-cycle pulses sampled on the rising clock
`timescale 1ns/1ns
module ats_seq_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic go_key,
    input wire logic escape_key,
    input wire logic stop_key,
    input wire logic commit_key,
    input wire logic loop_closed,
    input wire logic units_raw,
    input wire logic init_ok,
    input wire logic power_stable,
    input wire logic temp_stable,
    input wire logic over_temp,
    input wire logic model_done,
    input wire logic model_ok,
    input wire ats_pkg::ats_state_e status,
    input wire ats_pkg::ats_gains_s gains,
    input wire logic in_tune,
    input wire logic heater_off,
    input wire logic apply_gains,
    input wire logic resume_ctrl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic quiet;
    logic start_ok;
    assign quiet = !escape_key && !stop_key && !over_temp;
    assign start_ok = loop_closed && !units_raw && init_ok;
    sequence s_idle_go;
        in_tune && status == ats_pkg::ST_IDLE && go_key && quiet;
    endsequence
    sequence s_commit;
        apply_gains && resume_ctrl && !in_tune ##1 !apply_gains;
    endsequence
    chk_go_refused: assert property (
        s_idle_go ##0 !start_ok |=> status == ats_pkg::ST_IDLE)
        else $error("start taken without its conditions");
    chk_go_taken: assert property (
        s_idle_go ##0 start_ok |=> status == ats_pkg::ST_STAB)
        else $error("valid start not taken");
    chk_stab_hold: assert property (
        status == ats_pkg::ST_STAB && !(power_stable && temp_stable) && quiet
        |=> status == ats_pkg::ST_STAB)
        else $error("left stabilise while unsettled");
    chk_stab_leave: assert property (
        status == ats_pkg::ST_STAB && power_stable && temp_stable && quiet
        |=> status == ats_pkg::ST_RUN)
        else $error("settled but not running");
    chk_user_abort: assert property (
        (status == ats_pkg::ST_STAB || status == ats_pkg::ST_RUN) && !quiet
        |=> status == ats_pkg::ST_ABORT)
        else $error("abort not reported");
    chk_done_load: assert property (
        status == ats_pkg::ST_RUN && model_done && model_ok && quiet
        |=> status == ats_pkg::ST_DONE && gains.p_valid)
        else $error("completion not loaded");
    chk_gains_blank: assert property (
        in_tune && status != ats_pkg::ST_DONE |-> !gains.p_valid)
        else $error("gain shown before success");
    chk_commit_pulse: assert property (
        status == ats_pkg::ST_DONE && commit_key && !escape_key |=> s_commit)
        else $error("commit not applied");
    chk_commit_ignored: assert property (
        status != ats_pkg::ST_DONE && commit_key |=> !apply_gains)
        else $error("commit outside complete");
    chk_bad_model: assert property (
        status == ats_pkg::ST_RUN && model_done && !model_ok && quiet
        |=> status == ats_pkg::ST_FAIL)
        else $error("unusable model not failed");
    chk_escape_exit: assert property (
        in_tune && escape_key && status != ats_pkg::ST_STAB
        && status != ats_pkg::ST_RUN |=> !in_tune)
        else $error("escape did not leave tuning");
    chk_heat_cut: assert property (over_temp |-> heater_off)
        else $error("heater not cut");
endmodule : ats_seq_props

bind ats_seq ats_seq_props u_props (.clk, .rstn, .go_key, .escape_key,
    .stop_key, .commit_key, .loop_closed, .units_raw, .init_ok,
    .power_stable, .temp_stable, .over_temp, .model_done, .model_ok,
    .status, .gains, .in_tune, .heater_off, .apply_gains, .resume_ctrl);

// ===== sim/ats_plant.sv
// stand-in for the heater loop and modelling engine
// assumes settle, conv and bad are levels driven by the bench
`timescale 1ns/1ns
module ats_plant #(
    parameter logic [31:0] GP = 32'h0000_0001,
    parameter logic [31:0] GI = 32'h0000_0002,
    parameter logic [31:0] GD = 32'h0000_0003
) (
    input wire logic clk,
    input wire logic settle,
    input wire logic conv,
    input wire logic bad,
    input wire logic [3:0] lat,
    input wire logic model_run,
    output logic power_stable,
    output logic temp_stable,
    output logic model_done,
    output logic model_ok,
    output logic [31:0] gen_p,
    output logic [31:0] gen_i,
    output logic [31:0] gen_d
);
    int s = 0;
    int c = 0;
    logic flip = 1'b0;
    always @(posedge clk) begin
        s <= settle ? s + 1 : 0;
        c <= model_run ? c + 1 : 0;
        flip <= ~flip;
    end
    // a large lat models a slow rig; unqualified lines keep toggling
    assign power_stable = s > lat;
    // temperature settles one cycle after power, so both are needed
    assign temp_stable = s > lat + 1;
    assign model_done = conv && model_run && c == lat;
    assign model_ok = model_done ? !bad : flip;
    assign gen_p = model_done ? GP : {32{flip}};
    assign gen_i = model_done ? GI : {32{flip}};
    assign gen_d = model_done ? GD : {32{flip}};
endmodule : ats_plant

// ===== sim/ats_seq_test.sv
// self-checking bench for the autotune sequencer
// assumes ats_plant stands in for the heater loop
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error %0t %h %h", $time, a, b); end end
module ats_seq_test;
    localparam logic [31:0] GP = 32'h0000_0C80;
    localparam logic [31:0] GI = 32'h0000_0078;
    localparam logic [31:0] GD = 32'h0000_0028;
    logic clk = 0, rstn = 0, settle = 0, conv = 0, bad = 0;
    logic [4:0] keys = '0; // enter go escape stop commit
    logic loop_closed = 1, units_raw = 0, init_ok = 1, over_temp = 0;
    logic [0:0] loop_sel = '0, tune_loop, apply_loop;
    logic [6:0] step = 7'h14;
    ats_pkg::ats_mode_e mode = ats_pkg::MODE_PI;
    logic [15:0] tmo = 16'h0003;
    logic [9:0] cur = 10'h1F4, req = 10'h3E8, heater_power;
    logic [3:0] lat = 4'h1;
    logic power_stable, temp_stable, model_done, model_ok, model_run;
    logic [31:0] gp, gi, gd;
    ats_pkg::ats_state_e status;
    ats_pkg::ats_gains_s gains, e;
    logic heater_off, in_tune, apply_gains, resume_ctrl;
    int n_mismatch = 0, compares = 0;
    always #5 clk = ~clk;
    ats_seq #(.TICK_CYC(10), .LOOPS(2)) dut (.clk(clk), .rstn(rstn),
        .enter_key(keys[0]), .go_key(keys[1]), .escape_key(keys[2]),
        .stop_key(keys[3]), .commit_key(keys[4]), .loop_sel(loop_sel),
        .max_power_step_pct(step), .prop_integral_code(mode),
        .timeout_s(tmo), .loop_closed(loop_closed), .units_raw(units_raw),
        .init_ok(init_ok), .power_stable(power_stable),
        .temp_stable(temp_stable), .over_temp(over_temp), .cur_power(cur),
        .req_power(req), .model_done(model_done), .model_ok(model_ok),
        .gen_p(gp), .gen_i(gi), .gen_d(gd), .status(status), .gains(gains),
        .model_run(model_run), .heater_power(heater_power),
        .heater_off(heater_off), .in_tune(in_tune), .tune_loop(tune_loop),
        .apply_gains(apply_gains), .apply_loop(apply_loop),
        .resume_ctrl(resume_ctrl));
    ats_plant #(.GP(GP), .GI(GI), .GD(GD)) plant (.clk(clk),
        .settle(settle), .conv(conv), .bad(bad), .lat(lat),
        .model_run(model_run), .power_stable(power_stable),
        .temp_stable(temp_stable), .model_done(model_done),
        .model_ok(model_ok), .gen_p(gp), .gen_i(gi), .gen_d(gd));

    task automatic press(input int k);
        @(posedge clk) keys[k] <= 1'b1;
        @(posedge clk) keys <= '0;
        #1;
    endtask : press

    task automatic wait_st(input ats_pkg::ats_state_e st);
        for (int i = 0; i < 60 && status !== st; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_st

    task automatic to_run;
        press(0);
        press(1);
        settle <= 1'b1;
        wait_st(ats_pkg::ST_RUN);
        settle <= 1'b0;
        `CHK(status, ats_pkg::ST_RUN)
        `CHK(model_run, 1'b1)
    endtask : to_run

    task automatic final_report;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        press(0);
        `CHK(status, ats_pkg::ST_IDLE)
        `CHK(gains, '0)
        for (int j = 0; j < 3; j++) begin
            loop_closed <= j != 0;
            units_raw <= j == 1;
            init_ok <= j != 2;
            press(1);
            `CHK(status, ats_pkg::ST_IDLE)
        end
        loop_closed <= 1'b1;
        units_raw <= 1'b0;
        init_ok <= 1'b1;
        press(4);
        `CHK(apply_gains, 1'b0)
        press(1);
        repeat (40) @(posedge clk);
        #1 `CHK(status, ats_pkg::ST_STAB)
        `CHK(model_run, 1'b0)
        press(2);
        `CHK(status, ats_pkg::ST_ABORT)
        press(2);
        `CHK(in_tune, 1'b0)
        $display("test start done");
        lat <= 4'h8;
        to_run;
        // heater limit is 20 pct of 50.0 pct output, then full scale
        repeat (2) @(posedge clk);
        #1 `CHK(heater_power, 10'h258)
        req <= 10'h000;
        repeat (2) @(posedge clk);
        #1 `CHK(heater_power, 10'h190)
        step <= 7'h64;
        req <= 10'h3E8;
        repeat (2) @(posedge clk);
        #1 `CHK(heater_power, 10'h3E8)
        // three seconds of ten cycles, then one cycle to report
        repeat (24) @(posedge clk);
        #1 `CHK(status, ats_pkg::ST_RUN)
        @(posedge clk);
        #1 `CHK(status, ats_pkg::ST_FAIL)
        `CHK(gains.p_valid, 1'b0)
        press(4);
        `CHK(apply_gains, 1'b0)
        press(2);
        `CHK(in_tune, 1'b0)
        $display("test timeout done");
        step <= 7'h14;
        for (int k = 0; k < 3; k++) begin
            to_run;
            if (k == 2) begin
                over_temp <= 1'b1;
                #1 `CHK(heater_off, 1'b1)
                @(posedge clk);
                #1 over_temp <= 1'b0;
            end else press(k + 2);
            `CHK(status, ats_pkg::ST_ABORT)
            press(2);
        end
        $display("test abort done");
        conv <= 1'b1;
        lat <= 4'h1;
        for (int m = 0; m < 3; m++) begin
            mode <= ats_pkg::ats_mode_e'(m);
            loop_sel <= 1'(m);
            to_run;
            `CHK(tune_loop, 1'(m))
            wait_st(ats_pkg::ST_DONE);
            e = '{1'b1, m > 0, m == 2, GP, m > 0 ? GI : '0, m == 2 ? GD : '0};
            `CHK(status, ats_pkg::ST_DONE)
            `CHK(gains, e)
            press(m == 2 ? 4 : 2);
            `CHK(in_tune, 1'b0)
            `CHK(apply_gains, m == 2)
            `CHK(resume_ctrl, m == 2)
            if (m < 2) `CHK(gains.p_valid, 1'b0)
            else `CHK(apply_loop, 1'b0)
        end
        $display("test modes done");
        bad <= 1'b1;
        to_run;
        wait_st(ats_pkg::ST_FAIL);
        `CHK(status, ats_pkg::ST_FAIL)
        `CHK(gains.p_valid, 1'b0)
        press(2);
        `CHK(in_tune, 1'b0)
        $display("test bad model done");
        final_report;
    end

    initial begin
        #200000;
        n_mismatch++;
        final_report;
    end
endmodule : ats_seq_test
